// ===== hdl/rsc_top.sv
// rf sweep control: control link, sweep timing, synth programming,
// power leveling, receive switches and fault outputs
// assumes link_clk_i is driven by the processor only while it sends
`timescale 1ns/10ps
`include "rsc_cfg.svh"
module rsc_top import rsc_pkg::*; #(
	parameter int unsigned HALF1_CYC = `RSC_CLK_HZ / (2 * `RSC_PLAN1_HZ),
	parameter int unsigned HALF2_CYC = `RSC_CLK_HZ / (2 * `RSC_PLAN2_HZ),
	parameter int unsigned HALF3_CYC = `RSC_CLK_HZ / (2 * `RSC_PLAN3_HZ),
	parameter int unsigned LEVEL_CYC =
		`RSC_LEVEL_US * (`RSC_CLK_HZ / 1000000)
) (
	// clock, reset, enable
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	// processor link
	input wire logic link_clk_i,
	input wire logic link_data_i,
	input wire logic readback_sel_i,
	output logic link_return_o,
	// sweep timing
	input wire logic sweep_clear_i,
	output logic frame_sync_o,
	output logic sweep_dir_o,
	// receive path
	output logic receive_path_switch_a_o,
	output logic receive_path_switch_b_o,
	output logic calibration_path_switch_o,
	output logic lna_gain_select_a_o,
	output logic lna_gain_select_b_o,
	input wire logic lna_gain_sense_a_i,
	input wire logic lna_gain_sense_b_i,
	// ramp rate adc
	output logic rate_adc_select_n_o,
	output logic rate_adc_clock_o,
	input wire logic rate_adc_result_i,
	// main synthesizer
	output logic synth_main_select_n_o,
	output logic synth_main_clock_o,
	output logic synth_main_data_o,
	output logic synth_main_data_oe_o,
	input wire logic synth_main_data_i,
	input wire logic synth_main_readback_i,
	output logic synth_main_reset_o,
	output logic synth_main_port_sync_o,
	// monitor synthesizer
	output logic synth_mon_select_n_o,
	output logic synth_mon_clock_o,
	output logic synth_mon_data_o,
	output logic synth_mon_data_oe_o,
	input wire logic synth_mon_data_i,
	input wire logic synth_mon_readback_i,
	output logic synth_mon_reset_o,
	output logic synth_mon_port_sync_o,
	// synth sequencing
	output logic freq_update_strobe_o,
	output logic profile_select_o,
	// power leveling
	input wire logic power_low_comparator_i,
	input wire logic power_high_comparator_i,
	output logic [5:0] atten_line_o,
	// faults
	input wire logic loop_lock_input_i,
	input wire logic synth_miscompare_i,
	input wire logic ref384_error_i,
	input wire logic ref20_error_i,
	output logic rf_hw_fault_out_o,
	output logic rf_hw_fault_oe_o,
	output logic agc_mismatch_fault_out_o
);
	localparam int NPIN = 12;
	localparam longint REF9 = longint'(`RSC_PLL_DIV) * `RSC_REF_KHZ;

	function automatic rsc_ftw_t ftw(input longint khz);
		longint t;
		t = ((khz - REF9) * (longint'(1) << 32)) / REF9;
		return t[31:0];
	endfunction

	localparam rsc_ftw_t FTW_LO = ftw(`RSC_TX_LO_KHZ);
	localparam rsc_ftw_t FTW_HI = ftw(`RSC_TX_HI_KHZ);
	localparam rsc_ftw_t FTW_MID = ftw(`RSC_TX_MID_KHZ);

	// ==========================================
	// pin synchronisers
	logic [NPIN-1:0] pin_a_r;
	logic [NPIN-1:0] pin_r;
	logic [NPIN-1:0] pin_raw;
	assign pin_raw = {link_data_i, readback_sel_i, sweep_clear_i,
		rate_adc_result_i, power_low_comparator_i,
		power_high_comparator_i, lna_gain_sense_a_i,
		lna_gain_sense_b_i, loop_lock_input_i, synth_miscompare_i,
		ref384_error_i, ref20_error_i};
	generate
		for (genvar g = 0; g < NPIN; g++) begin : g_sync
			always_ff @(posedge clk_i or negedge nrst_i) begin
				if (!nrst_i) begin
					pin_a_r[g] <= 1'b0;
					pin_r[g] <= 1'b0;
				end else if (ce_i) begin
					pin_a_r[g] <= pin_raw[g];
					pin_r[g] <= pin_a_r[g];
				end
			end
		end
	endgenerate
	logic s_data, s_rbsel, s_clear, s_adc, s_plo, s_phi;
	logic s_fba, s_fbb, s_lock, s_miscmp, s_e384, s_e20;
	assign {s_data, s_rbsel, s_clear, s_adc, s_plo, s_phi, s_fba,
		s_fbb, s_lock, s_miscmp, s_e384, s_e20} = pin_r;

	// ==========================================
	// link domain: word assembly on the processor's clock
	logic [22:0] lsh_r;
	logic [4:0] lcnt_r;
	logic [23:0] lword_r;
	logic ltog_r;
	always_ff @(posedge link_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			lsh_r <= 23'h00_0000;
			lcnt_r <= 5'h00;
			lword_r <= 24'h00_0000;
			ltog_r <= 1'b0;
		end else if (lcnt_r == 5'(`RSC_WORD_BITS - 1)) begin
			lword_r <= {lsh_r, link_data_i};
			ltog_r <= !ltog_r;
			lcnt_r <= 5'h00;
		end else begin
			lsh_r <= {lsh_r[21:0], link_data_i};
			lcnt_r <= lcnt_r + 5'h01;
		end
	end

	// ==========================================
	// word hand-over: toggle crossing, word held for 24 link edges
	logic [2:0] tog_r;
	logic [23:0] ctrl_r;
	logic word_new;
	assign word_new = tog_r[2] ^ tog_r[1];
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tog_r <= 3'h0;
			ctrl_r <= 24'h00_0000;
		end else if (ce_i) begin
			tog_r <= {tog_r[1:0], ltog_r};
			if (word_new) begin
				ctrl_r <= lword_r;
			end
		end
	end
	logic [1:0] plan;
	assign plan = ctrl_r[`RSC_PLAN_LSB +: 2];

	// ==========================================
	// return line and receive path outputs
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			link_return_o <= 1'b0;
			receive_path_switch_a_o <= 1'b1;
			receive_path_switch_b_o <= 1'b0;
			calibration_path_switch_o <= 1'b0;
			lna_gain_select_a_o <= 1'b0;
			lna_gain_select_b_o <= 1'b0;
		end else if (ce_i) begin
			link_return_o <= s_rbsel ? frame_sync_o : s_data;
			receive_path_switch_a_o <= !ctrl_r[`RSC_RXSW_BIT];
			receive_path_switch_b_o <= ctrl_r[`RSC_RXSW_BIT];
			calibration_path_switch_o <= ctrl_r[`RSC_CALSW_BIT];
			lna_gain_select_a_o <= ctrl_r[`RSC_LNA_BIT];
			lna_gain_select_b_o <= ctrl_r[`RSC_LNA_BIT];
		end
	end

	// ==========================================
	// sweep timing
	logic [18:0] half_r;
	logic [18:0] half_lim;
	always_comb begin
		unique case (plan)
			2'b10: half_lim = 19'(HALF2_CYC - 1);
			2'b11: half_lim = 19'(HALF3_CYC - 1);
			default: half_lim = 19'(HALF1_CYC - 1);
		endcase
	end
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			half_r <= 19'h0_0000;
			sweep_dir_o <= 1'b0;
			frame_sync_o <= 1'b0;
		end else if (ce_i) begin
			if (s_clear) begin
				half_r <= 19'h0_0000;
				sweep_dir_o <= 1'b0;
				frame_sync_o <= 1'b0;
			end else if (half_r >= half_lim) begin
				half_r <= 19'h0_0000;
				sweep_dir_o <= !sweep_dir_o;
				if (!sweep_dir_o) begin
					frame_sync_o <= !frame_sync_o;
				end
			end else begin
				half_r <= half_r + 19'h0_0001;
			end
		end
	end

	// ==========================================
	// ramp rate adc, converted continuously
	rsc_adc_e adc_st_r;
	logic [6:0] adc_cnt_r;
	logic [4:0] adc_bit_r;
	logic [15:0] adc_sh_r;
	logic [11:0] rate_r;
	logic rate_new_r;
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			adc_st_r <= RSC_ADC_GAP;
			adc_cnt_r <= 7'h00;
			adc_bit_r <= 5'h00;
			adc_sh_r <= 16'h0000;
			rate_r <= 12'h000;
			rate_new_r <= 1'b0;
			rate_adc_select_n_o <= 1'b1;
			rate_adc_clock_o <= 1'b0;
		end else if (ce_i) begin
			rate_new_r <= 1'b0;
			adc_cnt_r <= adc_cnt_r + 7'h01;
			unique case (adc_st_r)
				RSC_ADC_GAP: begin
					if (adc_cnt_r == 7'(`RSC_ADC_GAP - 1)) begin
						adc_cnt_r <= 7'h00;
						adc_bit_r <= 5'h00;
						rate_adc_select_n_o <= 1'b0;
						adc_st_r <= RSC_ADC_RUN;
					end
				end
				RSC_ADC_RUN: begin
					if (adc_cnt_r == 7'(`RSC_SCLK_HALF - 1)) begin
						adc_cnt_r <= 7'h00;
						rate_adc_clock_o <= !rate_adc_clock_o;
						if (rate_adc_clock_o) begin
							adc_sh_r <= {adc_sh_r[14:0], s_adc};
							adc_bit_r <= adc_bit_r + 5'h01;
						end
					end
					if (adc_bit_r == 5'(`RSC_ADC_BITS)) begin
						rate_adc_select_n_o <= 1'b1;
						rate_adc_clock_o <= 1'b0;
						adc_cnt_r <= 7'h00;
						adc_st_r <= RSC_ADC_GAP;
						rate_r <= adc_sh_r[11:0];
						rate_new_r <= adc_sh_r[11:0] != rate_r;
					end
				end
			endcase
		end
	end

	// ==========================================
	// ramp parameters shared by both synthesizers
	rsc_ftw_t span, f_lo, f_hi;
	assign span = {8'h00, rate_r, 12'h000} << 0;
	always_comb begin
		unique case (plan)
			2'b10: begin
				f_hi = FTW_HI;
				f_lo = FTW_HI - span;
			end
			2'b11: begin
				f_lo = FTW_MID - (span >> 1);
				f_hi = FTW_MID + (span >> 1);
			end
			default: begin
				f_lo = FTW_LO;
				f_hi = FTW_LO + span;
			end
		endcase
	end

	// ==========================================
	// synthesizer sequencer
	rsc_seq_e seq_r;
	logic [4:0] seq_cnt_r;
	logic [1:0] idx_r;
	logic upd_r;
	logic syn_start_r, syn_read_r, rb_bad_r;
	logic [7:0] syn_addr_r;
	rsc_ftw_t syn_data_r, rb_word;
	logic busy_m, busy_s;
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			seq_r <= RSC_ST_RST;
			seq_cnt_r <= 5'h00;
			idx_r <= 2'h0;
			upd_r <= 1'b0;
			syn_start_r <= 1'b0;
			syn_read_r <= 1'b0;
			syn_addr_r <= 8'h00;
			syn_data_r <= 32'h0000_0000;
			rb_bad_r <= 1'b0;
			synth_main_reset_o <= 1'b1;
			synth_mon_reset_o <= 1'b1;
			synth_main_port_sync_o <= 1'b0;
			synth_mon_port_sync_o <= 1'b0;
			freq_update_strobe_o <= 1'b0;
		end else if (ce_i) begin
			syn_start_r <= 1'b0;
			freq_update_strobe_o <= 1'b0;
			synth_main_port_sync_o <= 1'b0;
			synth_mon_port_sync_o <= 1'b0;
			// new words and rates set the pending flag over a clear
			if (word_new || rate_new_r) begin
				upd_r <= 1'b1;
			end
			unique case (seq_r)
				RSC_ST_RST: begin
					seq_cnt_r <= seq_cnt_r + 5'h01;
					if (seq_cnt_r == 5'(`RSC_SYN_RST_CYC - 1)) begin
						synth_main_reset_o <= 1'b0;
						synth_mon_reset_o <= 1'b0;
						synth_main_port_sync_o <= 1'b1;
						synth_mon_port_sync_o <= 1'b1;
						syn_addr_r <= `RSC_REG_LO;
						syn_data_r <= FTW_MID;
						syn_read_r <= 1'b0;
						syn_start_r <= 1'b1;
						seq_r <= RSC_ST_INIT;
					end
				end
				RSC_ST_INIT: begin
					if (!syn_start_r && !busy_m && !busy_s) begin
						seq_r <= RSC_ST_FUD;
					end
				end
				RSC_ST_FUD: begin
					freq_update_strobe_o <= 1'b1;
					seq_r <= RSC_ST_IDLE;
				end
				RSC_ST_IDLE: begin
					if (upd_r && !word_new && !rate_new_r) begin
						upd_r <= 1'b0;
						idx_r <= 2'h0;
						seq_r <= RSC_ST_WR;
					end
				end
				RSC_ST_WR: begin
					if (!syn_start_r && !busy_m && !busy_s) begin
						idx_r <= idx_r + 2'h1;
						syn_read_r <= 1'b0;
						syn_start_r <= 1'b1;
						unique case (idx_r)
							2'h0: begin
								syn_addr_r <= `RSC_REG_LO;
								syn_data_r <= f_lo;
							end
							2'h1: begin
								syn_addr_r <= `RSC_REG_HI;
								syn_data_r <= f_hi;
							end
							2'h2: begin
								syn_addr_r <= `RSC_REG_STEP;
								syn_data_r <= {20'h0_0000, rate_r};
							end
							default: begin
								syn_addr_r <= `RSC_REG_LO;
								syn_data_r <= f_lo;
								syn_read_r <= 1'b1;
								seq_r <= RSC_ST_RD;
							end
						endcase
					end
				end
				RSC_ST_RD: begin
					if (!syn_start_r && !busy_m) begin
						rb_bad_r <= rb_word != syn_data_r;
						seq_r <= RSC_ST_IDLE;
					end
				end
				default: seq_r <= RSC_ST_RST;
			endcase
		end
	end

	// ==========================================
	// profile select follows sweep direction; the synths swap ramp
	// direction and take the newly loaded ramp words on each change
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			profile_select_o <= 1'b0;
		end else if (ce_i) begin
			profile_select_o <= sweep_dir_o;
		end
	end

	// ==========================================
	// same port to main and monitor synthesizers; the monitor gets the writes only, never the readback
	rsc_ser_port u_main (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.ce_i(ce_i),
		.start_i(syn_start_r),
		.read_i(syn_read_r),
		.addr_i(syn_addr_r),
		.data_i(syn_data_r),
		.busy_o(busy_m),
		.rdata_o(rb_word),
		.sel_n_o(synth_main_select_n_o),
		.sclk_o(synth_main_clock_o),
		.sdio_o(synth_main_data_o),
		.sdio_oe_o(synth_main_data_oe_o),
		.sdo_i(synth_main_readback_i)
	);
	rsc_ser_port u_mon (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.ce_i(ce_i),
		.start_i(syn_start_r && !syn_read_r),
		.read_i(1'b0),
		.addr_i(syn_addr_r),
		.data_i(syn_data_r),
		.busy_o(busy_s),
		.rdata_o(),
		.sel_n_o(synth_mon_select_n_o),
		.sclk_o(synth_mon_clock_o),
		.sdio_o(synth_mon_data_o),
		.sdio_oe_o(synth_mon_data_oe_o),
		.sdo_i(synth_mon_readback_i)
	);

	// ==========================================
	// power leveling
	logic [16:0] lvl_cnt_r;
	logic lvl_fail_r;
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			lvl_cnt_r <= 17'h0_0000;
			lvl_fail_r <= 1'b0;
			atten_line_o <= `RSC_ATTEN_RST;
		end else if (ce_i) begin
			lvl_cnt_r <= lvl_cnt_r + 17'h0_0001;
			if (lvl_cnt_r == 17'(LEVEL_CYC - 1)) begin
				lvl_cnt_r <= 17'h0_0000;
				lvl_fail_r <= 1'b0;
				if (!s_plo) begin
					if (atten_line_o != 6'h00) begin
						atten_line_o <= atten_line_o - 6'h01;
					end else begin
						lvl_fail_r <= 1'b1;
					end
				end else if (!s_phi) begin
					if (atten_line_o != 6'h3F) begin
						atten_line_o <= atten_line_o + 6'h01;
					end else begin
						lvl_fail_r <= 1'b1;
					end
				end
			end
		end
	end

	// ==========================================
	// fault reporting; the open-drain line only ever pulls low
	logic mm_d_r;
	logic mm;
	assign mm = s_fba ^ s_fbb;
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rf_hw_fault_out_o <= 1'b0;
			rf_hw_fault_oe_o <= 1'b0;
			agc_mismatch_fault_out_o <= 1'b0;
			mm_d_r <= 1'b0;
		end else if (ce_i) begin
			rf_hw_fault_oe_o <= lvl_fail_r || s_miscmp || rb_bad_r ||
				s_e384 || s_e20 || !s_lock;
			mm_d_r <= mm;
			if (mm && !mm_d_r) begin
				agc_mismatch_fault_out_o <= !agc_mismatch_fault_out_o;
			end
		end
	end
endmodule

// ===== hdl/rsc_cfg.svh
// timing counts, field positions and reset values of the rf sweep control
// assumes a 100 MHz system clock; included by bare name
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH
`define RSC_CLK_HZ 100000000
`define RSC_WORD_BITS 24
`define RSC_PLAN_LSB 0
`define RSC_RXSW_BIT 2
`define RSC_CALSW_BIT 3
`define RSC_LNA_BIT 4
`define RSC_PLAN1_HZ 145
`define RSC_PLAN2_HZ 150
`define RSC_PLAN3_HZ 155
`define RSC_TX_LO_KHZ 4235000
`define RSC_TX_HI_KHZ 4365000
`define RSC_TX_MID_KHZ 4300000
`define RSC_REF_KHZ 384000
`define RSC_PLL_DIV 9
`define RSC_SCLK_HALF 4
`define RSC_ADC_BITS 16
`define RSC_ADC_GAP 64
`define RSC_SYN_RST_CYC 16
`define RSC_SYN_FRAME 40
`define RSC_REG_LO 8'h01
`define RSC_REG_HI 8'h02
`define RSC_REG_STEP 8'h03
`define RSC_SPAN_SHIFT 12
`define RSC_LEVEL_US 1000
`define RSC_ATTEN_RST 6'h3F
`endif

// ===== hdl/rsc_pkg.sv
// types shared by the rf sweep control files
// assumes rsc_cfg.svh holds the numbers
package rsc_pkg;
	typedef enum logic [2:0] {
		RSC_ST_RST = 3'b000,
		RSC_ST_INIT = 3'b001,
		RSC_ST_FUD = 3'b010,
		RSC_ST_IDLE = 3'b011,
		RSC_ST_WR = 3'b100,
		RSC_ST_RD = 3'b101
	} rsc_seq_e;
	typedef enum logic [1:0] {
		RSC_ADC_GAP = 2'b00,
		RSC_ADC_RUN = 2'b01
	} rsc_adc_e;
	typedef logic [31:0] rsc_ftw_t;
endpackage

// ===== hdl/rsc_ser_port.sv
// serial register port to one frequency synthesizer
// assumes sdo_i is asynchronous; one 40-bit frame per start
`timescale 1ns/10ps
`include "rsc_cfg.svh"
module rsc_ser_port (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	// request
	input wire logic start_i,
	input wire logic read_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] data_i,
	output logic busy_o,
	output logic [31:0] rdata_o,
	// pins
	output logic sel_n_o,
	output logic sclk_o,
	output logic sdio_o,
	output logic sdio_oe_o,
	input wire logic sdo_i
);
	logic [39:0] sh_r;
	logic [5:0] bit_r;
	logic [2:0] div_r;
	logic [1:0] sdo_r;
	logic rd_r;
	// ==========================================
	// readback synchroniser
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sdo_r <= 2'h0;
		end else if (ce_i) begin
			sdo_r <= {sdo_r[0], sdo_i};
		end
	end
	// ==========================================
	// frame shifter, msb first, data set while clock low
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			busy_o <= 1'b0;
			sel_n_o <= 1'b1;
			sclk_o <= 1'b0;
			sdio_o <= 1'b0;
			sdio_oe_o <= 1'b0;
			sh_r <= 40'h00_0000_0000;
			bit_r <= 6'h00;
			div_r <= 3'h0;
			rdata_o <= 32'h0000_0000;
			rd_r <= 1'b0;
		end else if (ce_i) begin
			if (!busy_o) begin
				if (start_i) begin
					sh_r <= {read_i, addr_i[6:0], data_i};
					rd_r <= read_i;
					sdio_o <= read_i;
					sdio_oe_o <= 1'b1;
					sel_n_o <= 1'b0;
					busy_o <= 1'b1;
					bit_r <= 6'(`RSC_SYN_FRAME - 1);
					div_r <= 3'h0;
				end
			end else if (div_r == 3'(`RSC_SCLK_HALF - 1)) begin
				div_r <= 3'h0;
				sclk_o <= !sclk_o;
				if (!sclk_o) begin
					// sample late in the low phase to cover sync lag
					rdata_o <= {rdata_o[30:0], sdo_r[1]};
				end else if (bit_r == 6'h00) begin
					busy_o <= 1'b0;
					sel_n_o <= 1'b1;
					sdio_oe_o <= 1'b0;
				end else begin
					bit_r <= bit_r - 6'h01;
					sh_r <= {sh_r[38:0], 1'b0};
					sdio_o <= sh_r[38];
					// release the line for the data phase of a read
					// the read flag is gone from the shifter by now
					if (rd_r && bit_r == 6'h20) begin
						sdio_oe_o <= 1'b0;
					end
				end
			end else begin
				div_r <= div_r + 3'h1;
			end
		end
	end
endmodule

// ===== bench/rsc_top_checker.sv
// concurrent checks on the rf sweep control top ports
// assumes a bind into rsc_top; all checks in the clk_i domain
`timescale 1ns/10ps
module rsc_top_checker (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// watched inputs
	input wire logic sweep_clear_i,
	input wire logic loop_lock_input_i,
	input wire logic lna_gain_sense_a_i,
	input wire logic lna_gain_sense_b_i,
	// watched outputs
	input wire logic frame_sync_o,
	input wire logic sweep_dir_o,
	input wire logic receive_path_switch_a_o,
	input wire logic receive_path_switch_b_o,
	input wire logic lna_gain_select_a_o,
	input wire logic lna_gain_select_b_o,
	input wire logic synth_main_select_n_o,
	input wire logic synth_main_data_oe_o,
	input wire logic freq_update_strobe_o,
	input wire logic profile_select_o,
	input wire logic rf_hw_fault_out_o,
	input wire logic rf_hw_fault_oe_o,
	input wire logic agc_mismatch_fault_out_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);
	// =====================================================
	// sequences
	// windows are longer than the two-stage input synchronisers
	sequence clear_held;
		sweep_clear_i [*5];
	endsequence
	sequence lines_agree;
		(lna_gain_sense_a_i == lna_gain_sense_b_i) [*6];
	endsequence
	sequence lock_lost;
		!loop_lock_input_i [*6];
	endsequence
	// =====================================================
	// assertions
	rx_compl_a: assert property (
		receive_path_switch_a_o != receive_path_switch_b_o)
		else $error("receive switch lines not complementary");
	lna_pair_a: assert property (
		lna_gain_select_a_o == lna_gain_select_b_o)
		else $error("lna lines differ");
	sweep_clear_a: assert property (
		clear_held |-> !frame_sync_o && !sweep_dir_o)
		else $error("sweep outputs not held low");
	frame_on_dir_a: assert property ($rose(frame_sync_o) |-> sweep_dir_o)
		else $error("frame sync rose without sweep direction");
	profile_dir_a: assert property (profile_select_o == $past(sweep_dir_o))
		else $error("profile select not following direction");
	agc_quiet_a: assert property (
		lines_agree |=> $stable(agc_mismatch_fault_out_o))
		else $error("agc fault toggled without disagreement");
	lock_fault_a: assert property (lock_lost |-> rf_hw_fault_oe_o)
		else $error("rf fault missing on lock loss");
	rf_pin_a: assert property (!rf_hw_fault_out_o)
		else $error("rf fault line driven high");
	synth_frame_a: assert property (
		$fell(synth_main_select_n_o) |-> !synth_main_select_n_o [*8])
		else $error("synth select too short");
	sdio_sel_a: assert property (synth_main_data_oe_o |-> !synth_main_select_n_o)
		else $error("synth data driven while deselected");
	fud_pulse_a: assert property (
		freq_update_strobe_o |=> !freq_update_strobe_o)
		else $error("update strobe longer than one cycle");
endmodule
bind rsc_top rsc_top_checker chk (.clk_i(clk_i), .nrst_i(nrst_i),
	.sweep_clear_i(sweep_clear_i), .loop_lock_input_i(loop_lock_input_i),
	.lna_gain_sense_a_i(lna_gain_sense_a_i),
	.lna_gain_sense_b_i(lna_gain_sense_b_i),
	.frame_sync_o(frame_sync_o), .sweep_dir_o(sweep_dir_o),
	.receive_path_switch_a_o(receive_path_switch_a_o),
	.receive_path_switch_b_o(receive_path_switch_b_o),
	.lna_gain_select_a_o(lna_gain_select_a_o),
	.lna_gain_select_b_o(lna_gain_select_b_o),
	.synth_main_select_n_o(synth_main_select_n_o),
	.synth_main_data_oe_o(synth_main_data_oe_o),
	.freq_update_strobe_o(freq_update_strobe_o),
	.profile_select_o(profile_select_o),
	.rf_hw_fault_out_o(rf_hw_fault_out_o),
	.rf_hw_fault_oe_o(rf_hw_fault_oe_o),
	.agc_mismatch_fault_out_o(agc_mismatch_fault_out_o));

// ===== bench/rsc_proc_model.sv
// model of the processor end of the serial control link
// assumes the bench calls send_word; link clock idles low between words
`timescale 1ns/10ps
module rsc_proc_model (
	// link pins
	output logic link_clk_o,
	output logic link_data_o
);
	initial begin
		link_clk_o = 1'b0;
		link_data_o = 1'b0;
	end
	// msb first at a 6 ns period; the clock stands still after the word
	task automatic send_word(input logic [23:0] w);
		for (int i = 23; i >= 0; i--) begin
			link_data_o = w[i];
			#3 link_clk_o = 1'b1;
			#3 link_clk_o = 1'b0;
		end
		// released line shows the inverse so a stale bit is never trusted
		link_data_o = ~w[0];
	endtask
endmodule

// ===== bench/tb_rf_sweep_control_logic.sv
// self-checking bench for the rf sweep control top
// assumes rsc_top with shortened sweep and leveling counts
`timescale 1ns/10ps
`include "rsc_cfg.svh"
module tb_rf_sweep_control_logic;
	localparam int LV = 20;
	localparam int half_cyc [3] = '{30, 28, 26};
	// 4.3 GHz carrier as a tuning word: (f - 9 x 384 MHz) / (9 x 384 MHz) x 2^32
	localparam logic [31:0] mid_w = 32'h3E84_BDA1;
	logic clk, nrst = 0, rsel = 0, clr = 0, plo = 1, phi = 1, lock = 1;
	logic m384 = 0, m20 = 0, mis = 0, brk = 0, adc_bit = 0, rb = 0;
	logic lclk, ldat, ret, fs, dir, rxa, rxb, cal, la, lb, asel, aclk;
	logic ms, mc, md, moe, mrst, msync, ns, nc, nd, noe, nrs, nsync;
	logic freq_update_strobe, ps, flt, foe, agc, mon_seen, sync_seen;
	logic [5:0] att, nb;
	logic [39:0] sh;
	logic [31:0] lo_q;
	int miscompares = 0, n_tests = 0;
	rsc_top #(.HALF1_CYC(half_cyc[0]), .HALF2_CYC(half_cyc[1]),
		.HALF3_CYC(half_cyc[2]), .LEVEL_CYC(LV)) uut (
		.clk_i(clk), .nrst_i(nrst), .ce_i(1'b1),
		.link_clk_i(lclk), .link_data_i(ldat), .readback_sel_i(rsel),
		.link_return_o(ret), .sweep_clear_i(clr), .frame_sync_o(fs),
		.sweep_dir_o(dir), .receive_path_switch_a_o(rxa),
		.receive_path_switch_b_o(rxb), .calibration_path_switch_o(cal),
		.lna_gain_select_a_o(la), .lna_gain_select_b_o(lb),
		.lna_gain_sense_a_i(la), .lna_gain_sense_b_i(lb ^ brk),
		.rate_adc_select_n_o(asel), .rate_adc_clock_o(aclk),
		.rate_adc_result_i(adc_bit),
		.synth_main_select_n_o(ms), .synth_main_clock_o(mc),
		.synth_main_data_o(md), .synth_main_data_oe_o(moe),
		.synth_main_data_i(md), .synth_main_readback_i(rb),
		.synth_main_reset_o(mrst), .synth_main_port_sync_o(msync),
		.synth_mon_select_n_o(ns), .synth_mon_clock_o(nc),
		.synth_mon_data_o(nd), .synth_mon_data_oe_o(noe),
		.synth_mon_data_i(nd), .synth_mon_readback_i(rb),
		.synth_mon_reset_o(nrs), .synth_mon_port_sync_o(nsync),
		.freq_update_strobe_o(freq_update_strobe), .profile_select_o(ps),
		.power_low_comparator_i(plo), .power_high_comparator_i(phi),
		.atten_line_o(att), .loop_lock_input_i(lock),
		.synth_miscompare_i(mis), .ref384_error_i(m384),
		.ref20_error_i(m20), .rf_hw_fault_out_o(flt),
		.rf_hw_fault_oe_o(foe), .agc_mismatch_fault_out_o(agc));
	rsc_proc_model proc (.link_clk_o(lclk), .link_data_o(ldat));
	// =====================================================
	// synth and adc stand-ins
	// the low register is echoed back so a good design sees no disagreement
	// an undriven data line reads low, so a dropped enable shows up
	always @(posedge mc) if (!ms) sh <= {sh[38:0], md & moe};
	always @(negedge ms or posedge mc) nb <= (mc && !ms) ? nb + 6'h01 : 6'h00;
	always @(posedge ms)
		if (nb == 6'h28 && sh[39:32] == `RSC_REG_LO) lo_q <= sh[31:0];
	// released readback line shows the inverse of its last bit
	always @(negedge mc or posedge ms) begin
		if (ms)
			rb <= ~rb;
		else if (nb >= 6'h08 && nb < 6'h28)
			rb <= lo_q[6'h27 - nb];
	end
	always @(negedge aclk) adc_bit <= ~adc_bit;
	always @(negedge ns) mon_seen = 1'b1;
	always @(posedge msync) sync_seen = 1'b1;
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// =====================================================
	// tasks
	task automatic complete_run();
		if (miscompares == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic check(input logic ok, input string what);
		n_tests++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("MISMATCH %0t %s", $time, what);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wait_hi(ref logic s, input int lim);
		int k;
		k = 0;
		while (s !== 1'b1 && k < lim) begin
			cyc(1);
			k++;
		end
	endtask
	task automatic wait_att(input logic [5:0] v);
		int k;
		k = 0;
		while (att === v && k < 4 * LV) begin
			cyc(1);
			k++;
		end
	endtask
	// full period between two rising edges, in clk cycles
	task automatic period(ref logic s, output int n);
		n = 0;
		while (s !== 1'b0 && n < 400) begin cyc(1); n++; end
		while (s !== 1'b1 && n < 400) begin cyc(1); n++; end
		n = 0;
		while (s !== 1'b0 && n < 400) begin cyc(1); n++; end
		while (s !== 1'b1 && n < 400) begin cyc(1); n++; end
	endtask
	task automatic restart();
		nrst = 1'b0;
		mon_seen = 1'b0;
		sync_seen = 1'b0;
		cyc(4);
		check(rxa === 1'b1 && att === `RSC_ATTEN_RST, "reset outputs");
		check(mrst === 1'b1 && nrs === 1'b1 && ms === 1'b1, "synth reset");
		nrst = 1'b1;
		wait_hi(freq_update_strobe, 4000);
		check(freq_update_strobe === 1'b1 && mrst === 1'b0 && nrs === 1'b0, "init");
		check(mon_seen === 1'b1 && sync_seen === 1'b1, "synth init");
		check(lo_q === mid_w, "init word");
	endtask
	task automatic set_cause(input int c, input logic v);
		case (c)
			0: lock = ~v;
			1: mis = v;
			2: m384 = v;
			3: m20 = v;
			default: phi = ~v;
		endcase
	endtask
	// =====================================================
	// tests
	initial begin
		int n;
		logic [23:0] w;
		logic a0;
		restart();
		for (int p = 0; p < 3; p++) begin
			w = {19'h0_0000, ~p[0], p[1], p[0], 2'(p + 1)};
			proc.send_word(w);
			cyc(8);
			check(rxa === ~w[2] && rxb === w[2] && cal === w[3], "switch");
			check(la === w[4] && lb === w[4], "lna gain");
			check(ret === ~w[0], "echo");
			period(dir, n);
			check(n == 2 * half_cyc[p], "sweep period");
			period(fs, n);
			check(n == 4 * half_cyc[p], "frame period");
		end
		check(ret === ~w[0], "echo");
		rsel = 1'b1;
		wait_hi(fs, 200);
		cyc(5);
		check(ret === 1'b1 && fs === 1'b1, "return frame");
		clr = 1'b1;
		cyc(100);
		check(fs === 1'b0 && dir === 1'b0 && ret === 1'b0, "clear");
		clr = 1'b0;
		check(att === 6'h3F, "level hold");
		plo = 1'b0;
		wait_att(6'h3F);
		plo = 1'b1;
		check(att === 6'h3E, "level down");
		phi = 1'b0;
		wait_att(6'h3E);
		phi = 1'b1;
		check(att === 6'h3F, "level up");
		cyc(3 * LV);
		check(att === 6'h3F && foe === 1'b0, "level stop");
		a0 = agc;
		brk = 1'b1;
		cyc(10);
		check(agc === ~a0, "agc toggle");
		cyc(20);
		brk = 1'b0;
		cyc(10);
		check(agc === ~a0, "agc once");
		for (int c = 0; c < 5; c++) begin
			restart();
			check(foe === 1'b0, "fault idle");
			set_cause(c, 1'b1);
			wait_hi(foe, 4 * LV + 20);
			check(foe === 1'b1 && flt === 1'b0, "fault raise");
			set_cause(c, 1'b0);
		end
		complete_run();
	end
	initial begin
		repeat (90000) @(posedge clk);
		miscompares++;
		complete_run();
	end
endmodule
